// ### shared/wte_defines.svh
`ifndef WTE_DEFINES_SVH
`define WTE_DEFINES_SVH
// Absolute-jump form opcode, bits 15..10
`define WTE_ABS_OPCODE 6'h04
`define WTE_ABS_OP_HI 15
`define WTE_ABS_OP_LO 10
`define WTE_ABS_JREG_BIT 9
// Relative-jump form marker, bits 15..14
`define WTE_REL_MARK 2'h3
`define WTE_REL_OFS_HI 13
`define WTE_REL_OFS_LO 9
// Common fields
`define WTE_ROW_HI 8
`define WTE_ROW_LO 6
`define WTE_COND_HI 5
`define WTE_COND_LO 0
// Condition code groups
`define WTE_CC_FLAG_LOW 2'h0
`define WTE_CC_FLAG_HIGH 2'h1
`define WTE_CC_TC_BASE 6'h20
`define WTE_CC_START_LOW 6'h24
`define WTE_CC_START_HIGH 6'h25
`define WTE_CC_SC_V_LOW 6'h26
`define WTE_CC_SC_S_LOW 6'h29
`define WTE_CC_SC_V_HIGH 6'h2c
`define WTE_CC_ALU_DONE 6'h2f
`define WTE_CC_BOOST_HIGH 6'h30
`define WTE_CC_BOOST_LOW 6'h31
`define WTE_CC_CUR_HIGH 6'h32
`define WTE_CC_CUR_LOW 6'h38
`define WTE_CC_OWN_HIGH 6'h3e
`define WTE_CC_OWN_LOW 6'h3f
`define WTE_ROW_MAX 3'h4
`endif

// ### shared/wte_pkg.sv
`default_nettype none
package wte_pkg;
   // Kind of destination stored in a row
   typedef enum logic {WTE_DEST_ABS, WTE_DEST_REL} wte_dest_kind_t;
endpackage
`default_nettype wire

// ### rtl/wte_wait_table.sv
`timescale 1ns/1ps
`default_nettype none
`include "wte_defines.svh"
// Functional notes
// - Five rows, each condition plus destination
// - All five rows evaluated concurrently
// - Enabled true row redirects to destination
// - Absolute form destination from jump register
// - Absolute operand limited to jump registers
// - Flags low/high, terminal counts, start decode
// - Shortcut drain-source/source feedback decode
// - Code 101111 true on ALU completion
// - Boost voltage and current feedback decode
// - Own current feedback high and low
// - Row codes 000..100 select rows 1..5
// - Relative destination based on instruction location
// - Destination is instruction address plus offset
// - Offset is 5-bit two's complement
module wte_wait_table
   import wte_pkg::*;
#(
   parameter int ADDR_W = 10, // Code RAM address width
   parameter int ROWS = 5, // Wait table rows
   parameter int FLAGS = 16 // Flag inputs
) (
   // Clock and asynchronous reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Instruction stream from the fetch stage
   input wire logic [15:0] instr_in, // Instruction being executed
   input wire logic instr_valid_in, // Instruction executes this cycle
   input wire logic [ADDR_W-1:0] pc_in, // Code RAM address of that instruction
   // Jump register subset, one operand bit picks
   input wire logic [ADDR_W-1:0] jump_register_0_in, // Jump register 1
   input wire logic [ADDR_W-1:0] jump_register_1_in, // Jump register 2
   // Condition sources, all plain levels
   // Taken as synchronous; no synchronisers here
   input wire logic [FLAGS-1:0] flags_in,
   input wire logic [3:0] terminal_count_in, // Counters 1..4
   input wire logic start_in,
   input wire logic [2:0] shortcut_drain_fb_in, // Shortcuts 1..3 drain-source
   input wire logic [2:0] shortcut_source_fb_in, // Shortcuts 1..3 source
   input wire logic alu_done_in, // Requested ALU operation finished
   input wire logic boost_voltage_high_in,
   input wire logic [5:0] current_fb_in, // 1,2,3,4l,4h,4n
   input wire logic own_current_fb_in,
   // Wait instruction side
   input wire logic waiting_in, // Wait instruction active
   input wire logic [ROWS-1:0] row_enable_in, // Rows enabled by the wait
   // Results
   output logic load_done_out, // Row written this cycle
   output logic jump_out, // Take the jump
   output logic [ADDR_W-1:0] jump_addr_out, // Destination
   output logic [ROWS-1:0] row_hit_out // Enabled rows whose condition is true
);
   // Elaboration check
   // The condition decoder is built for exactly these sizes
   // Code space must at least hold the offset range
   if (ROWS != 5 || FLAGS != 16 || ADDR_W < 5) begin : g_bad_params
      $error("wte_wait_table: unsupported parameters");
   end

   // Table columns; relative rows hold the resolved address
   logic [5:0] cond_reg [ROWS];
   logic [ADDR_W-1:0] dest_reg [ROWS];
   wte_dest_kind_t kind_reg [ROWS];
   logic load_done_reg;
   logic jump_reg;
   logic [ADDR_W-1:0] jump_addr_reg;

   // Instruction decode
   // Purely combinational; the table write lands on the next edge
   // The two forms never overlap: marker 11 cannot match the opcode
   wire is_abs = instr_valid_in &&
      instr_in[`WTE_ABS_OP_HI:`WTE_ABS_OP_LO] == `WTE_ABS_OPCODE;
   wire is_rel = instr_valid_in &&
      instr_in[15:14] == `WTE_REL_MARK;
   wire [2:0] row_sel = instr_in[`WTE_ROW_HI:`WTE_ROW_LO];
   wire row_ok = row_sel <= `WTE_ROW_MAX; // codes above are ignored
   wire [5:0] cond_sel = instr_in[`WTE_COND_HI:`WTE_COND_LO];
   // Only one bit selects within the jump register subset
   wire jreg_sel = instr_in[`WTE_ABS_JREG_BIT];
   wire [ADDR_W-1:0] abs_dest = jreg_sel ? jump_register_1_in
      : jump_register_0_in;
   wire [4:0] rel_ofs = instr_in[`WTE_REL_OFS_HI:`WTE_REL_OFS_LO];
   // Sign extension gives -16..15
   wire [ADDR_W-1:0] rel_ofs_ext = {{(ADDR_W-5){rel_ofs[4]}}, rel_ofs};
   // Resolved at load time so the wait sees a plain address
   // Wraps modulo the code space; no overflow is reported
   wire [ADDR_W-1:0] rel_dest = pc_in + rel_ofs_ext;
   // Undefined rows never reach the write
   wire load = (is_abs || is_rel) && row_ok;

   // Condition evaluator for one code
   // Code map, top bits first:
   //   00xxxx flag low, 01xxxx flag high
   //   100000..100011 terminal counts
   //   100100 and 100101 start low and high
   //   100110..101110 shortcut feedbacks
   //   101111 arithmetic unit finished
   //   110000..111101 boost and current feedbacks
   //   111110 and 111111 own current feedback
   // Ordered range tests keep each group one compare
   // Trade-off: a priority chain, but each row has its own copy
   function automatic logic cond_true(input logic [5:0] c);
      logic r;
      r = 1'b0;
      if (c[5:4] == `WTE_CC_FLAG_LOW) begin
         r = ~flags_in[c[3:0]];
      end else if (c[5:4] == `WTE_CC_FLAG_HIGH) begin
         r = flags_in[c[3:0]];
      end else if (c < `WTE_CC_START_LOW) begin
         r = terminal_count_in[c[1:0]];
      end else if (c == `WTE_CC_START_LOW) begin
         r = ~start_in;
      end else if (c == `WTE_CC_START_HIGH) begin
         r = start_in;
      end else if (c < `WTE_CC_SC_S_LOW) begin
         r = ~shortcut_drain_fb_in[2'(c - `WTE_CC_SC_V_LOW)];
      end else if (c < `WTE_CC_SC_V_HIGH) begin
         r = ~shortcut_source_fb_in[2'(c - `WTE_CC_SC_S_LOW)];
      end else if (c < `WTE_CC_ALU_DONE) begin
         r = shortcut_drain_fb_in[2'(c - `WTE_CC_SC_V_HIGH)];
      end else if (c == `WTE_CC_ALU_DONE) begin
         r = alu_done_in;
      end else if (c == `WTE_CC_BOOST_HIGH) begin
         r = boost_voltage_high_in;
      end else if (c == `WTE_CC_BOOST_LOW) begin
         r = ~boost_voltage_high_in;
      end else if (c < `WTE_CC_CUR_LOW) begin
         r = current_fb_in[3'(c - `WTE_CC_CUR_HIGH)];
      end else if (c < `WTE_CC_OWN_HIGH) begin
         r = ~current_fb_in[3'(c - `WTE_CC_CUR_LOW)];
      end else if (c == `WTE_CC_OWN_HIGH) begin
         r = own_current_fb_in;
      end else begin
         r = ~own_current_fb_in;
      end
      return r;
   endfunction

   // One evaluator per row, all in parallel
   // Costs five decoders, but no row waits for another
   logic [ROWS-1:0] hit;
   genvar g;
   generate
      for (g = 0; g < ROWS; g++) begin : g_row
         assign hit[g] = row_enable_in[g] && cond_true(cond_reg[g]);
      end
   endgenerate

   // Lowest numbered hit row wins when several fire together
   // Loop runs downward so the lowest row is assigned last
   logic [ADDR_W-1:0] sel_dest;
   logic any_hit;
   always_comb begin
      sel_dest = '0;
      any_hit = 1'b0;
      for (int i = ROWS - 1; i >= 0; i--) begin
         if (hit[i]) begin
            sel_dest = dest_reg[i];
            any_hit = 1'b1;
         end
      end
   end

   // Table write
   // Reset condition is flag 0 low; harmless while rows are disabled
   // Destination kind is stored per row but drives no output
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         for (int i = 0; i < ROWS; i++) begin
            cond_reg[i] <= 6'h00;
            dest_reg[i] <= '0;
            kind_reg[i] <= WTE_DEST_ABS;
         end
      end else if (load) begin
         cond_reg[row_sel] <= cond_sel;
         dest_reg[row_sel] <= is_abs ? abs_dest : rel_dest;
         kind_reg[row_sel] <= is_abs ? WTE_DEST_ABS : WTE_DEST_REL;
      end
   end

   // Registered outputs
   // One cycle of latency; address follows every cycle
   // Jump only while the wait is active
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         load_done_reg <= 1'b0;
         jump_reg <= 1'b0;
         jump_addr_reg <= '0;
      end else begin
         load_done_reg <= load;
         jump_reg <= waiting_in && any_hit;
         jump_addr_reg <= sel_dest;
      end
   end

   // Output drive; row hits stay combinational for the wait stage
   assign load_done_out = load_done_reg;
   assign jump_out = jump_reg;
   assign jump_addr_out = jump_addr_reg;
   assign row_hit_out = hit;
endmodule
`default_nettype wire

// ### bench/wte_wait_table_sva.sv
`timescale 1ns/1ps
`default_nettype none
module wte_wait_table_sva #(
   parameter int ROWS = 5 // Wait table rows
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic [15:0] instr_in,
   input wire logic instr_valid_in,
   input wire logic own_current_fb_in,
   input wire logic waiting_in,
   input wire logic [ROWS-1:0] row_enable_in,
   input wire logic load_done_out,
   input wire logic jump_out,
   input wire logic [ROWS-1:0] row_hit_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   // Legal loads; rows above five are never taken
   wire logic row_ok = instr_in[8:6] <= 3'h4;
   wire logic abs_take = instr_valid_in && instr_in[15:10] == 6'h04 && row_ok;
   wire logic rel_take = instr_valid_in && instr_in[15:14] == 2'h3 && row_ok;
   wire logic any_hit = waiting_in && (|row_hit_out);
   abs_load_a: assert property (abs_take |=> load_done_out) else $error("abs load lost");
   rel_load_a: assert property (rel_take |=> load_done_out) else $error("rel load lost");
   bad_row_a: assert property (instr_valid_in && !row_ok |=> !load_done_out)
      else $error("undefined row loaded");
   idle_load_a: assert property (!(abs_take || rel_take) |=> !load_done_out)
      else $error("load without instruction");
   jump_take_a: assert property (any_hit |=> jump_out) else $error("jump missed");
   jump_hold_a: assert property (!any_hit |=> !jump_out) else $error("spurious jump");
   hit_gate_a: assert property ((row_hit_out & ~row_enable_in) == '0)
      else $error("disabled row hit");
   own_hit_a: assert property (abs_take && instr_in[8:6] == 3'h0 && instr_in[5:0] == 6'h3e
      ##1 row_enable_in[0] && own_current_fb_in |-> row_hit_out[0])
      else $error("own feedback row missed");
endmodule
bind wte_wait_table wte_wait_table_sva #(.ROWS(ROWS)) u_sva (
   .sys_clk_in(sys_clk_in),
   .reset_in(reset_in),
   .instr_in(instr_in),
   .instr_valid_in(instr_valid_in),
   .own_current_fb_in(own_current_fb_in),
   .waiting_in(waiting_in),
   .row_enable_in(row_enable_in),
   .load_done_out(load_done_out),
   .jump_out(jump_out),
   .row_hit_out(row_hit_out)
);
`default_nettype wire

// ### bench/wait_table_entry_setup_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module wait_table_entry_setup_tb_top;
   logic sys_clk_in = 1'b0; // 25 MHz
   logic reset_in = 1'b1;
   logic [15:0] instr = 16'h0000;
   logic valid = 1'b0;
   logic [9:0] pc = 10'h000, jr0 = 10'h000, jr1 = 10'h000;
   logic [35:0] cv = '0; // Every condition input, own feedback at bit 0
   logic waiting = 1'b0;
   logic [4:0] en = 5'h00;
   logic load_done, jump;
   logic [9:0] jaddr;
   logic [4:0] hit;
   int n_fail = 0;
   int checks = 0;
   always #20 sys_clk_in = ~sys_clk_in;
   wte_wait_table DUT (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .instr_in(instr),
      .instr_valid_in(valid), .pc_in(pc), .jump_register_0_in(jr0), .jump_register_1_in(jr1),
      .flags_in(cv[35:20]), .terminal_count_in(cv[19:16]), .start_in(cv[15]),
      .shortcut_drain_fb_in(cv[14:12]), .shortcut_source_fb_in(cv[11:9]), .alu_done_in(cv[8]),
      .boost_voltage_high_in(cv[7]), .current_fb_in(cv[6:1]), .own_current_fb_in(cv[0]),
      .waiting_in(waiting), .row_enable_in(en), .load_done_out(load_done), .jump_out(jump),
      .jump_addr_out(jaddr), .row_hit_out(hit));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One load; second jump register is the inverse, so bit 9 matters
   task automatic load(input logic [15:0] ins, input logic [9:0] at, input logic [9:0] j,
                       input logic exp);
      @(posedge sys_clk_in);
      {instr, valid, pc, jr0, jr1} <= {ins, 1'b1, at, j, ~j};
      @(posedge sys_clk_in);
      valid <= 1'b0;
      #1 chk("load_done", {15'h0000, load_done}, {15'h0000, exp});
   endtask
   // Conditions plus enables for one cycle of wait, then judge the jump
   task automatic probe(input logic [35:0] c, input logic [4:0] e, input logic [4:0] eh,
                        input logic ej, input logic [9:0] ea);
      @(posedge sys_clk_in);
      {cv, en, waiting} <= {c, e, 1'b1};
      #1 chk("row_hit", {11'h000, hit}, {11'h000, eh});
      @(posedge sys_clk_in);
      waiting <= 1'b0;
      #1 chk("jump", {15'h0000, jump}, {15'h0000, ej});
      if (ej) chk("jump_addr", {6'h00, jaddr}, {6'h00, ea});
   endtask
   // Condition code to {level when true, input bit}
   function automatic logic [6:0] cmap(input int c);
      if (c < 16) return {1'b0, 6'(20 + c)};
      if (c < 32) return {1'b1, 6'(c + 4)};
      if (c < 36) return {1'b1, 6'(c - 16)};
      if (c < 38) return {c[0], 6'h0f};
      if (c < 41) return {1'b0, 6'(c - 26)};
      if (c < 47) return {c > 43, 6'(c - 32)};
      if (c < 49) return {1'b1, 6'(55 - c)};
      if (c == 49) return {1'b0, 6'h07};
      if (c < 56) return {1'b1, 6'(c - 49)};
      if (c < 62) return {1'b0, 6'(c - 55)};
      return {c == 62, 6'h00};
   endfunction
   // All other inputs opposite, so a wrong bit or level shows up
   task automatic t_codes();
      logic [6:0] m;
      logic [35:0] one;
      for (int c = 0; c < 64; c++) begin
         m = cmap(c);
         one = 36'h1 << m[5:0];
         load({6'h04, 1'b0, 3'h0, 6'(c)}, 10'h000, 10'(c * 5), 1'b1);
         probe(m[6] ? ~one : one, 5'h01, 5'h00, 1'b0, 10'h000);
         probe(m[6] ? one : ~one, 5'h01, 5'h01, 1'b1, 10'(c * 5));
      end
      $display("test codes done");
   endtask
   // Each row via the second jump register; undefined rows refused
   task automatic t_rows();
      for (int r = 0; r < 8; r++) begin
         load({6'h04, 1'b1, 3'(r), 6'h3e}, 10'h000, 10'(85 + r), r < 5);
         if (r < 5) probe(36'h1, 5'(1 << r), 5'(1 << r), 1'b1, ~10'(85 + r));
      end
      probe(36'h1, 5'h1f, 5'h1f, 1'b1, ~10'h055);
      $display("test rows done");
   endtask
   // Offset extremes, one wrapping past the top of code space
   task automatic t_rel();
      load({2'h3, 5'h10, 3'h4, 6'h3f}, 10'h100, 10'h2aa, 1'b1);
      load({2'h3, 5'h0f, 3'h0, 6'h3e}, 10'h3f8, 10'h2aa, 1'b1);
      probe(36'h0, 5'h10, 5'h10, 1'b1, 10'h0f0);
      probe(36'h1, 5'h11, 5'h01, 1'b1, 10'h007);
      $display("test relative done");
   endtask
   task automatic summarize();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge sys_clk_in);
      n_fail++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      #1 chk("reset_outs", {8'h00, load_done, jump, hit}, 16'h0000);
      t_codes();
      t_rows();
      t_rel();
      summarize();
   end
endmodule
`default_nettype wire
